// ---- reset_strap_cfg.svh ----
`ifndef RESET_STRAP_CFG_SVH
`define RESET_STRAP_CFG_SVH

// ------------------------------------------------------------
// Strap pins
// ------------------------------------------------------------
`define CFG_PIN_COUNT     16
// Low four pins carry the clock ratio straps and have no pull-up
`define CFG_PULLUP_MASK   16'hFFF0
`define CFG_VALUE_RESET   16'h0000

// ------------------------------------------------------------
// Timing in platform clocks
// ------------------------------------------------------------
`define CFG_HOLD_CLKS     4
`define CFG_CNT_W         3
`define CFG_HOLD_LOAD     3'h3

// ------------------------------------------------------------
// Test access controller
// ------------------------------------------------------------
`define TAP_TMS_ONES      5
`define TAP_CNT_W         3
`define TAP_CNT_LAST      3'h4

`endif

// ---- reset_strap_pkg.sv ----
`include "reset_strap_cfg.svh"

package reset_strap_pkg;

    typedef logic [`CFG_PIN_COUNT-1:0] cfg_bus_t;

    typedef enum logic [1:0] {
        PH_IN_RESET,
        PH_PULLUP_HOLD,
        PH_RUNNING
    } phase_t;

    typedef struct packed {
        phase_t                phase;
        logic [`CFG_CNT_W-1:0] cnt;
        cfg_bus_t              value;
        logic                  valid;
        logic                  rcv_en;
        cfg_bus_t              pullup_en;
        cfg_bus_t              pin_out;
        cfg_bus_t              pin_oe;
    } latch_state_t;

    typedef struct packed {
        logic                  tck_prev;
        logic [`TAP_CNT_W-1:0] ones;
        logic                  in_reset;
    } tap_state_t;

endpackage

// ---- tap_reset_tracker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "reset_strap_cfg.svh"

module tap_reset_tracker
    import reset_strap_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic trst_n,
    output logic      tap_reset
);

    tap_state_t s_q;
    tap_state_t s_d;
    logic       tck_rise;

    assign tck_rise = tck & ~s_q.tck_prev;

    // ------------------------------------------------------------
    // Reset state reached by five TMS-high clocks, no TRST needed
    // ------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.tck_prev = tck;
        if (!trst_n)
        begin
            s_d.ones     = '0;
            s_d.in_reset = 1'b1;
        end
        else if (tck_rise)
        begin
            if (!tms)
            begin
                s_d.ones     = '0;
                s_d.in_reset = 1'b0;
            end
            else if (s_q.ones == `TAP_CNT_LAST)
            begin
                s_d.in_reset = 1'b1;
            end
            else
            begin
                s_d.ones = s_q.ones + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{tck_prev: 1'b0, ones: '0, in_reset: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tap_reset = s_q.in_reset;

    property p_tap_tms_reset;
        @(posedge clk) disable iff (!rst_n)
        (trst_n && tck_rise && tms && s_q.ones == `TAP_CNT_LAST) |=> tap_reset;
    endproperty
    a_tap_tms_reset: assert property (p_tap_tms_reset)
        else $error("TAP did not enter reset after five TMS-high clocks");

endmodule

`default_nettype wire

// ---- reset_strap_config_latch.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "reset_strap_cfg.svh"

module reset_strap_config_latch
    import reset_strap_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic hard_reset_n,
    input  wire cfg_bus_t cfg_pin_in,
    input  wire cfg_bus_t func_out,
    input  wire cfg_bus_t func_oe,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic trst_n,
    output cfg_bus_t  cfg_pin_out,
    output cfg_bus_t  cfg_pin_oe,
    output logic      cfg_rcv_en,
    output cfg_bus_t  cfg_pullup_en,
    output cfg_bus_t  cfg_value,
    output logic      cfg_valid,
    output logic      tap_reset
);

    latch_state_t s_q;
    latch_state_t s_d;

    // ------------------------------------------------------------
    // Strap sequencing
    // ------------------------------------------------------------
    // Pull-ups stay on after capture so a slow pull-down edge has settled
    // before the pin becomes an output again.
    always_comb
    begin
        s_d         = s_q;
        s_d.pin_out = '0;
        s_d.pin_oe  = '0;
        if (!hard_reset_n)
        begin
            s_d.phase     = PH_IN_RESET;
            s_d.valid     = 1'b0;
            s_d.rcv_en    = 1'b1;
            s_d.pullup_en = `CFG_PULLUP_MASK;
        end
        else
        begin
            unique case (s_q.phase)
                PH_IN_RESET:
                begin
                    s_d.phase = PH_PULLUP_HOLD;
                    s_d.cnt   = `CFG_HOLD_LOAD;
                    s_d.value = cfg_pin_in;
                    s_d.valid = 1'b1;
                end
                PH_PULLUP_HOLD:
                begin
                    if (s_q.cnt == '0)
                    begin
                        s_d.phase     = PH_RUNNING;
                        s_d.rcv_en    = 1'b0;
                        s_d.pullup_en = '0;
                        s_d.pin_out   = func_out;
                        s_d.pin_oe    = func_oe;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
                PH_RUNNING:
                begin
                    s_d.pin_out = func_out;
                    s_d.pin_oe  = func_oe;
                end
                default:
                begin
                    s_d.phase = PH_IN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{phase: PH_IN_RESET, cnt: '0, value: `CFG_VALUE_RESET, valid: 1'b0,
                     rcv_en: 1'b1, pullup_en: `CFG_PULLUP_MASK, pin_out: '0, pin_oe: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign cfg_pin_out   = s_q.pin_out;
    assign cfg_pin_oe    = s_q.pin_oe;
    assign cfg_rcv_en    = s_q.rcv_en;
    assign cfg_pullup_en = s_q.pullup_en;
    assign cfg_value     = s_q.value;
    assign cfg_valid     = s_q.valid;

    // ------------------------------------------------------------
    // Test access controller reset tracking
    // ------------------------------------------------------------
    tap_reset_tracker u_tap
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .tck       (tck),
        .tms       (tms),
        .trst_n    (trst_n),
        .tap_reset (tap_reset)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_input_in_reset;
        @(posedge clk) disable iff (!rst_n)
        !hard_reset_n |=> (cfg_pin_oe == '0) && cfg_rcv_en && !cfg_valid;
    endproperty
    a_input_in_reset: assert property (p_input_in_reset)
        else $error("Strap pin driven or receiver off during hard reset");

    property p_latch_on_release;
        @(posedge clk) disable iff (!rst_n)
        $rose(hard_reset_n) |=> cfg_valid && (cfg_value == $past(cfg_pin_in));
    endproperty
    a_latch_on_release: assert property (p_latch_on_release)
        else $error("Strap value not captured at reset release");

    property p_pullup_hold;
        @(posedge clk) disable iff (!rst_n)
        $rose(hard_reset_n) ##1 hard_reset_n[*4]
            |-> (cfg_pullup_en == `CFG_PULLUP_MASK) ##1 (cfg_pullup_en == '0);
    endproperty
    a_pullup_hold: assert property (p_pullup_hold)
        else $error("Pull-up not held for the set clocks after release");

    property p_pullup_with_rcv;
        @(posedge clk) disable iff (!rst_n)
        $fell(cfg_rcv_en) |-> ($past(cfg_pullup_en) != '0) && (cfg_pullup_en == '0);
    endproperty
    a_pullup_with_rcv: assert property (p_pullup_with_rcv)
        else $error("Pull-up and receiver did not switch off together");

    property p_pullup_mask;
        @(posedge clk) disable iff (!rst_n)
        cfg_rcv_en |-> (cfg_pullup_en == `CFG_PULLUP_MASK);
    endproperty
    a_pullup_mask: assert property (p_pullup_mask)
        else $error("Pull-up pattern differs from default-high straps");

    property p_value_stable;
        @(posedge clk) disable iff (!rst_n)
        (cfg_valid && hard_reset_n) |=> $stable(cfg_value);
    endproperty
    a_value_stable: assert property (p_value_stable)
        else $error("Latched strap value changed outside hard reset");

    property p_no_drive_before_release;
        @(posedge clk) disable iff (!rst_n)
        cfg_rcv_en |-> (cfg_pin_oe == '0);
    endproperty
    a_no_drive_before_release: assert property (p_no_drive_before_release)
        else $error("Strap pin driven while receiver still enabled");

    property p_tap_trst;
        @(posedge clk) disable iff (!rst_n)
        !trst_n |=> tap_reset;
    endproperty
    a_tap_trst: assert property (p_tap_trst)
        else $error("TAP not in reset after test reset");

endmodule

`default_nettype wire

// ---- strap_board.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Board strap resistors and pin wiring
// ----------------------------------------
module strap_board
    import reset_strap_pkg::*;
(
    input  wire logic       clk,
    input  wire cfg_bus_t   strap_low,
    input  wire logic [3:0] ratio,
    input  wire cfg_bus_t   pin_out,
    input  wire cfg_bus_t   pin_oe,
    input  wire cfg_bus_t   pullup_en,
    output var  cfg_bus_t   pin_in
);
    // Undriven pins above the ratio straps with no pull-down or pull-up toggle, so a stale level is never mistaken for a strap
    cfg_bus_t flt_q;

    initial flt_q = 16'h0000;

    always @(posedge clk)
        flt_q <= ~flt_q;

    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (i < 4)
                pin_in[i] = ratio[i];
            else if (strap_low[i])
                pin_in[i] = 1'b0;
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt_q[i];
        end
    end
endmodule

`default_nettype wire

// ---- reset_strap_config_latch_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "reset_strap_cfg.svh"

module reset_strap_config_latch_test
    import reset_strap_pkg::*;
;
    logic       clk, rst_n, hard_reset_n, tck, tms, trst_n;
    logic       sys_hrst_n, dbg_hrst_n, dbg_trst_n, trst_link;
    cfg_bus_t   pin_in, func_out, func_oe, pin_out, pin_oe, pullup_en, value, strap_low;
    logic [3:0] ratio;
    logic       rcv_en, valid, tap_reset;
    int         n_mismatch, n_compared;

    reset_strap_config_latch dut (.clk(clk), .rst_n(rst_n), .hard_reset_n(hard_reset_n),
        .cfg_pin_in(pin_in), .func_out(func_out), .func_oe(func_oe), .tck(tck), .tms(tms),
        .trst_n(trst_n), .cfg_pin_out(pin_out), .cfg_pin_oe(pin_oe), .cfg_rcv_en(rcv_en),
        .cfg_pullup_en(pullup_en), .cfg_value(value), .cfg_valid(valid),
        .tap_reset(tap_reset));

    strap_board board (.clk(clk), .strap_low(strap_low), .ratio(ratio), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .pin_in(pin_in));

    // Board reset logic: debug hard reset merges with the system source; TRST follows it when linked, else dbg_trst_n
    assign hard_reset_n = sys_hrst_n & dbg_hrst_n;
    assign trst_n       = trst_link ? hard_reset_n : dbg_trst_n;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc();
        @(negedge clk);
    endtask

    task automatic tck_pulse(input logic m);
        tms = m;
        tck = 1'b1;
        cyc();
        tck = 1'b0;
        cyc();
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("TB: compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_capture(input cfg_bus_t pd, input logic [3:0] r);
        int n;
        strap_low    = pd;
        ratio        = r;
        sys_hrst_n   = 1'b0;
        repeat (3) cyc();
        chk("oe in reset", 16'h0000, pin_oe);
        chk("rcv in reset", 16'h0001, {15'h0, rcv_en});
        chk("pullup in reset", 16'hFFF0, pullup_en);
        chk("valid in reset", 16'h0000, {15'h0, valid});
        sys_hrst_n   = 1'b1;
        n = 0;
        cyc();
        while (valid !== 1'b1 && n < 4)
        begin
            n++;
            cyc();
        end
        chk("value", (~pd & 16'hFFF0) | {12'h000, r}, value);
        n = 0;
        while (rcv_en === 1'b1 && n < 8)
        begin
            chk("pullup in hold", 16'hFFF0, pullup_en);
            chk("oe in hold", 16'h0000, pin_oe);
            n++;
            cyc();
        end
        chk("hold clocks", 16'(`CFG_HOLD_CLKS), 16'(n));
        chk("pullup off", 16'h0000, pullup_en);
        cyc();
        chk("pin out", func_out, pin_out);
        chk("pin oe", func_oe, pin_oe);
        $display("TB: capture test done");
    endtask

    task automatic t_stable();
        cfg_bus_t old;
        old       = value;
        strap_low = ~strap_low;
        ratio     = ~ratio;
        func_oe   = 16'hFFFF;
        repeat (6) cyc();
        chk("value held", old, value);
        dbg_hrst_n = 1'b0;
        repeat (2) cyc();
        chk("valid cleared", 16'h0000, {15'h0, valid});
        chk("value kept in reset", old, value);
        chk("oe released", 16'h0000, pin_oe);
        func_oe    = 16'h0FF0;
        dbg_hrst_n = 1'b1;
        t_capture(16'h0F30, 4'hA);
        $display("TB: stable test done");
    endtask

    task automatic t_tap();
        tck_pulse(1'b0);
        chk("tap left reset", 16'h0000, {15'h0, tap_reset});
        dbg_trst_n = 1'b0;
        repeat (2) cyc();
        chk("tap trst", 16'h0001, {15'h0, tap_reset});
        chk("straps kept", 16'h0001, {15'h0, valid});
        dbg_trst_n = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            tck_pulse(i != 0);
            chk("tap tms", (i == 5) ? 16'h0001 : 16'h0000, {15'h0, tap_reset});
        end
        tck_pulse(1'b0);
        chk("tap left again", 16'h0000, {15'h0, tap_reset});
        trst_link  = 1'b1;
        sys_hrst_n = 1'b0;
        repeat (2) cyc();
        chk("tap linked", 16'h0001, {15'h0, tap_reset});
        chk("linked valid", 16'h0000, {15'h0, valid});
        sys_hrst_n = 1'b1;
        trst_link  = 1'b0;
        repeat (2) cyc();
        $display("TB: tap test done");
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        sys_hrst_n = 1'b0;
        dbg_hrst_n = 1'b1;
        trst_link = 1'b0;
        dbg_trst_n = 1'b0;
        tck = 1'b0;
        tms = 1'b0;
        strap_low = 16'h0000;
        ratio = 4'h0;
        func_out = 16'hA5C3;
        func_oe = 16'h0FF0;
        repeat (5) cyc();
        rst_n = 1'b1;
        dbg_trst_n = 1'b1;
        t_capture(16'hC0A0, 4'h5);
        t_stable();
        t_tap();
        test_done();
    end

    initial
    begin
        #16000;
        n_mismatch++;
        test_done();
    end
endmodule

`default_nettype wire
